//--- shared/ccd_pkg.sv
package ccd_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SYNC_HOLD_NS = 20;
    localparam int SYNC_HOLD_CYC = (SYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SYNC_HOLD_LOAD = 4'(SYNC_HOLD_CYC - 1);

    // register indices; the byte address is four times the index
    localparam logic [9:0] IDX_CH0_CYC = 10'h190;
    localparam logic [9:0] IDX_CH0_BYP = 10'h191;
    localparam logic [9:0] IDX_CH0_CTL = 10'h192;
    localparam logic [9:0] IDX_CH1_CYC = 10'h196;
    localparam logic [9:0] IDX_CH1_BYP = 10'h197;
    localparam logic [9:0] IDX_CH1_CTL = 10'h198;
    localparam logic [9:0] IDX_PREDIV = 10'h1e0;
    localparam logic [9:0] IDX_SRC_SEL = 10'h1e1;
    localparam logic [9:0] IDX_SYNC_CTL = 10'h1f0;
    localparam logic [9:0] IDX_STATUS = 10'h1f1;

    // field positions
    localparam int LOW_LSB = 4;
    localparam int HIGH_LSB = 0;
    localparam int BYPASS_BIT = 7;
    localparam int START_HIGH_BIT = 4;
    localparam int PHASE_LSB = 0;
    localparam int DIRECT_BIT = 1;
    localparam int DUTY_FIX_DIS_BIT = 0;
    localparam int SYNC_REQ_BIT = 0;

    // writable bits and reset values
    localparam logic [7:0] BYP_MASK = 8'h9f;
    localparam logic [7:0] CTL_MASK = 8'h03;
    localparam logic [7:0] PREDIV_MASK = 8'h07;
    localparam logic [7:0] SRC_MASK = 8'h03;
    localparam logic [7:0] CYC_RST = 8'h00;
    localparam logic [7:0] BYP_RST = 8'h00;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] PREDIV_RST = 8'h02;
    localparam logic [7:0] SRC_RST = 8'h00;

    // source select codes
    localparam logic [1:0] SRC_EXT_PD = 2'h0;
    localparam logic [1:0] SRC_EXT_NOPD = 2'h1;
    localparam logic [1:0] SRC_VCO_PD = 2'h2;

    typedef enum {SY_HOLD, SY_RUN} ccd_sync_e;

    // a sampled clock level with its edge pulses
    typedef struct packed {
        logic lvl;
        logic rise;
        logic fall;
    } ccd_edge_s;

    typedef struct packed {
        logic [3:0] low_w;
        logic [3:0] high_w;
        logic bypass;
        logic start_high;
        logic [3:0] phase_off;
        logic dcc_en;
        logic direct;
    } ccd_chan_cfg_s;

    function automatic logic [5:0] ccd_ratio(input ccd_chan_cfg_s c);
        return {2'h0, c.high_w} + {2'h0, c.low_w} + 6'h02;
    endfunction : ccd_ratio

    function automatic logic [5:0] ccd_delay(input ccd_chan_cfg_s c);
        return c.start_high ? {2'h0, c.phase_off} + {2'h0, c.low_w} + 6'h01
                            : {2'h0, c.phase_off};
    endfunction : ccd_delay

    function automatic logic [2:0] ccd_prediv_ratio(input logic [2:0] sel);
        if (sel < 3'h2) begin
            return 3'h2;
        end
        if (sel > 3'h6) begin
            return 3'h6;
        end
        return sel;
    endfunction : ccd_prediv_ratio
endpackage : ccd_pkg

//--- verilog/ccd_prediv.sv
module ccd_prediv (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // selected source and settings
    input wire ccd_pkg::ccd_edge_s src_edge,
    input wire logic [2:0] ratio_sel,
    input wire logic sync_hold,
    // divided stream and delay-matched undivided stream
    output ccd_pkg::ccd_edge_s div_edge,
    output ccd_pkg::ccd_edge_s raw_edge
);
    logic [2:0] ratio;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic lvl_d;

    assign ratio = ccd_pkg::ccd_prediv_ratio(ratio_sel); // [RULE4]
    assign cnt_d = (cnt_q == ratio - 3'h1) ? 3'h0 : cnt_q + 3'h1;
    // high for the lower half, so odd ratios run short of 50%
    assign lvl_d = cnt_d < {1'b0, ratio[2:1]}; // [RULE13]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 3'h0;
        end else if (sync_hold) begin
            cnt_q <= ratio - 3'h1;
        end else if (src_edge.rise) begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_edge <= '0;
        end else if (sync_hold) begin
            div_edge <= '0;
        end else if (src_edge.rise) begin
            div_edge <= {lvl_d, lvl_d & ~div_edge.lvl, ~lvl_d & div_edge.lvl};
        end else begin
            div_edge <= {div_edge.lvl, 2'h0};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_edge <= '0;
        end else begin
            raw_edge <= src_edge;
        end
    end
endmodule : ccd_prediv

//--- verilog/ccd_chan_div.sv
module ccd_chan_div (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // divider input and aligned undivided source
    input wire ccd_pkg::ccd_edge_s div_in,
    input wire ccd_pkg::ccd_edge_s src_in,
    input wire logic stretch_en,
    // settings, stable outside sync
    input wire ccd_pkg::ccd_chan_cfg_s cfg,
    input wire logic sync_hold,
    // divided output
    output logic div_q
);
    logic [5:0] ratio;
    logic [5:0] high_cnt;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic [5:0] dly_q;
    logic pend_q;
    logic stretch_q;

    assign ratio = ccd_pkg::ccd_ratio(cfg); // [RULE8] [RULE5]
    assign high_cnt = cfg.dcc_en ? {1'b0, ratio[5:1]} : {2'h0, cfg.high_w} + 6'h01; // [RULE11]
    assign cnt_d = (cnt_q == ratio - 6'h01) ? 6'h00 : cnt_q + 6'h01;

    // bypass keeps the counter parked; restart is clean on the next sync
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 6'h00;
            dly_q <= 6'h00;
        end else if (sync_hold || cfg.bypass) begin // [RULE6] [RULE23]
            cnt_q <= ratio - 6'h01;
            dly_q <= ccd_pkg::ccd_delay(cfg); // [RULE18] [RULE21]
        end else if (div_in.rise) begin // [RULE9]
            if (dly_q != 6'h00) begin
                dly_q <= dly_q - 6'h01; // [RULE17]
            end else begin
                cnt_q <= cnt_d;
            end
        end
    end

    // bypassed, odd prediv with correction: hold high to the next source fall
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stretch_q <= 1'b0;
        end else if (sync_hold || !cfg.bypass) begin
            stretch_q <= 1'b0;
        end else if (div_in.fall && stretch_en) begin // [RULE14]
            stretch_q <= 1'b1;
        end else if (src_in.fall) begin
            stretch_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (sync_hold) begin // [RULE19]
            div_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (cfg.bypass) begin // [RULE15] [RULE13]
            div_q <= div_in.lvl | ((stretch_q | (div_in.fall & stretch_en)) & ~src_in.fall);
            pend_q <= 1'b0;
        end else if (div_in.rise && dly_q == 6'h00) begin
            if (cnt_d == 6'h00) begin
                div_q <= 1'b1;
            end else if (cnt_d == high_cnt) begin
                if (cfg.dcc_en && ratio[0]) begin // [RULE15]
                    pend_q <= 1'b1;
                end else begin
                    div_q <= 1'b0; // [RULE12]
                end
            end
        end else if (div_in.fall && pend_q) begin // [RULE11]
            div_q <= 1'b0;
            pend_q <= 1'b0;
        end
    end
endmodule : ccd_chan_div

//--- verilog/ccd_clock_channel_divider.sv
// Summary of operation
// RULE1: source code 00 takes the external clock, 10 the internal vco, both via prediv.
// RULE2: direct bit of each channel routes the prediv input straight to its pair.
// RULE3: with prediv in path, total division is prediv ratio times channel ratio.
// RULE4: prediv divides by 2, 3, 4, 5 or 6 from a three-bit field.
// RULE5: channel divides by 2 to 32, or by 1 when bypassed.
// RULE6: bypass passes input undivided and parks the channel counter.
// RULE7: cycle register holds low width in upper nibble, high width in lower, minus one.
// RULE8: output high for high width plus one, low for low width plus one cycles.
// RULE9: high and low periods count cycles of the divider's own input clock.
// RULE10: duty correction is on after reset, off per channel by duty_fix_disable.
// RULE11: correction gives 50% for even equal widths or odd with low one longer.
// RULE12: uncorrected duty is high width plus one over the full ratio.
// RULE13: bypassed, uncorrected, prediv 3 gives 33.3%, prediv 5 gives 40%.
// RULE14: bypassed and corrected, odd prediv stretches high to the next source fall.
// RULE15: no prediv: bypass keeps source duty; odd corrected adds source high time.
// RULE16: direct route carries the source's own duty, 50% from the vco.
// RULE17: phase offset delays the first rising edge by whole input cycles.
// RULE18: delay comes from offset field and start_high_bit, which adds low width.
// RULE19: offsets apply only at sync; software issues a sync after changing them.
// RULE20: start_high_bit is bit 4, phase_offset_field bits 3 to 0 of bypass register.
// RULE21: delay is phi when phi is at most 15, else phi minus 16 plus low plus one.
// RULE22: software never writes source code 11; vco always needs the prediv.
// RULE23: ratio, bypass and correction changes take effect cleanly at the next sync.
module ccd_clock_channel_divider (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock sources, sampled levels
    input wire logic ext_clk_in,
    input wire logic vco_clk_in,
    // output pairs
    output logic first_pair_out_a,
    output logic first_pair_out_b,
    output logic second_pair_out_a,
    output logic second_pair_out_b
);
    logic [1:0][7:0] cyc_q;
    logic [1:0][7:0] byp_q;
    logic [1:0][7:0] ctl_q;
    logic [7:0] prediv_q;
    logic [7:0] src_q;
    logic [7:0] status;
    logic [7:0] rd_mux;
    logic [9:0] idx;
    logic hit;
    logic access;
    logic wr_en;
    logic sync_req;
    logic [31:0] prdata_q;

    ccd_pkg::ccd_sync_e state_q;
    logic [3:0] hold_cnt_q;
    logic sync_hold;

    ccd_pkg::ccd_chan_cfg_s [1:0] cur_cfg;
    ccd_pkg::ccd_chan_cfg_s [1:0] act_cfg_q;
    logic [1:0] act_src_q;
    logic [2:0] act_pd_q;
    logic [2:0] act_pd_ratio;
    logic pd_used;

    logic sel_lvl;
    logic sel_prev_q;
    ccd_pkg::ccd_edge_s src_edge;
    ccd_pkg::ccd_edge_s pd_div;
    ccd_pkg::ccd_edge_s pd_raw;
    ccd_pkg::ccd_edge_s ch_in;
    logic [1:0] stretch_en;
    logic [1:0] chan_out;
    logic [1:0] out_q;

    function automatic ccd_pkg::ccd_chan_cfg_s mk_cfg(input logic [7:0] cyc,
                                                      input logic [7:0] byp,
                                                      input logic [7:0] ctl);
        ccd_pkg::ccd_chan_cfg_s c;
        c.low_w = cyc[ccd_pkg::LOW_LSB +: 4]; // [RULE7]
        c.high_w = cyc[ccd_pkg::HIGH_LSB +: 4];
        c.bypass = byp[ccd_pkg::BYPASS_BIT];
        c.start_high = byp[ccd_pkg::START_HIGH_BIT]; // [RULE20]
        c.phase_off = byp[ccd_pkg::PHASE_LSB +: 4];
        c.dcc_en = !ctl[ccd_pkg::DUTY_FIX_DIS_BIT]; // [RULE10]
        c.direct = ctl[ccd_pkg::DIRECT_BIT];
        return c;
    endfunction : mk_cfg

    // apb decode; registers are word aligned, data in the low byte
    assign idx = paddr[11:2];
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign wr_en = access && pwrite && hit && pstrb[0];
    assign sync_req = wr_en && idx == ccd_pkg::IDX_SYNC_CTL && pwdata[ccd_pkg::SYNC_REQ_BIT];
    assign prdata = prdata_q;
    assign status = {4'h0, pd_used, out_q[1], out_q[0], sync_hold};

    always_comb begin
        hit = paddr[1:0] == 2'h0;
        rd_mux = 8'h00;
        case (idx)
            ccd_pkg::IDX_CH0_CYC: rd_mux = cyc_q[0];
            ccd_pkg::IDX_CH0_BYP: rd_mux = byp_q[0];
            ccd_pkg::IDX_CH0_CTL: rd_mux = ctl_q[0];
            ccd_pkg::IDX_CH1_CYC: rd_mux = cyc_q[1];
            ccd_pkg::IDX_CH1_BYP: rd_mux = byp_q[1];
            ccd_pkg::IDX_CH1_CTL: rd_mux = ctl_q[1];
            ccd_pkg::IDX_PREDIV: rd_mux = prediv_q;
            ccd_pkg::IDX_SRC_SEL: rd_mux = src_q;
            ccd_pkg::IDX_SYNC_CTL: rd_mux = 8'h00;
            ccd_pkg::IDX_STATUS: rd_mux = status;
            default: hit = 1'b0;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_q <= {2{ccd_pkg::CYC_RST}};
            byp_q <= {2{ccd_pkg::BYP_RST}};
            ctl_q <= {2{ccd_pkg::CTL_RST}};
            prediv_q <= ccd_pkg::PREDIV_RST;
            src_q <= ccd_pkg::SRC_RST;
        end else if (wr_en) begin
            case (idx)
                ccd_pkg::IDX_CH0_CYC: cyc_q[0] <= pwdata[7:0];
                ccd_pkg::IDX_CH0_BYP: byp_q[0] <= pwdata[7:0] & ccd_pkg::BYP_MASK;
                ccd_pkg::IDX_CH0_CTL: ctl_q[0] <= pwdata[7:0] & ccd_pkg::CTL_MASK;
                ccd_pkg::IDX_CH1_CYC: cyc_q[1] <= pwdata[7:0];
                ccd_pkg::IDX_CH1_BYP: byp_q[1] <= pwdata[7:0] & ccd_pkg::BYP_MASK;
                ccd_pkg::IDX_CH1_CTL: ctl_q[1] <= pwdata[7:0] & ccd_pkg::CTL_MASK;
                ccd_pkg::IDX_PREDIV: prediv_q <= pwdata[7:0] & ccd_pkg::PREDIV_MASK;
                ccd_pkg::IDX_SRC_SEL: src_q <= pwdata[7:0] & ccd_pkg::SRC_MASK;
                default: ;
            endcase
        end
    end

    // sync: hold channel divider outputs low (direct routes still toggle), reload settings, then release
    assign sync_hold = state_q == ccd_pkg::SY_HOLD;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ccd_pkg::SY_HOLD;
            hold_cnt_q <= ccd_pkg::SYNC_HOLD_LOAD;
        end else begin
            case (state_q)
                ccd_pkg::SY_HOLD: begin
                    if (hold_cnt_q == 4'h0) begin
                        state_q <= ccd_pkg::SY_RUN;
                    end else begin
                        hold_cnt_q <= hold_cnt_q - 4'h1;
                    end
                end
                ccd_pkg::SY_RUN: begin
                    if (sync_req) begin // [RULE19]
                        state_q <= ccd_pkg::SY_HOLD;
                        hold_cnt_q <= ccd_pkg::SYNC_HOLD_LOAD;
                    end
                end
                default: state_q <= ccd_pkg::SY_HOLD;
            endcase
        end
    end

    assign cur_cfg[0] = mk_cfg(cyc_q[0], byp_q[0], ctl_q[0]);
    assign cur_cfg[1] = mk_cfg(cyc_q[1], byp_q[1], ctl_q[1]);

    // working settings change only while held in sync
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_cfg_q <= '0;
            act_src_q <= ccd_pkg::SRC_RST[1:0];
            act_pd_q <= ccd_pkg::PREDIV_RST[2:0];
        end else if (sync_hold) begin // [RULE23] [RULE19]
            act_cfg_q <= cur_cfg;
            act_src_q <= src_q[1:0];
            act_pd_q <= prediv_q[2:0];
        end
    end

    // source selection and edge extraction
    assign sel_lvl = (act_src_q == ccd_pkg::SRC_VCO_PD) ? vco_clk_in : ext_clk_in; // [RULE1]
    assign src_edge = {sel_lvl, sel_lvl & ~sel_prev_q, ~sel_lvl & sel_prev_q};
    // code 11 is never written; it behaves as 00
    assign pd_used = act_src_q != ccd_pkg::SRC_EXT_NOPD; // [RULE22]
    assign act_pd_ratio = ccd_pkg::ccd_prediv_ratio(act_pd_q);
    assign ch_in = pd_used ? pd_div : pd_raw; // [RULE3]

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_lvl;
        end
    end

    ccd_prediv u_prediv (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .src_edge(src_edge),
        .ratio_sel(act_pd_q),
        .sync_hold(sync_hold),
        .div_edge(pd_div),
        .raw_edge(pd_raw)
    );

    for (genvar i = 0; i < 2; i++) begin : g_chan
        assign stretch_en[i] = act_cfg_q[i].dcc_en && pd_used && act_pd_ratio[0]; // [RULE14]

        ccd_chan_div u_chan (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .div_in(ch_in),
            .src_in(pd_raw),
            .stretch_en(stretch_en[i]),
            .cfg(act_cfg_q[i]),
            .sync_hold(sync_hold),
            .div_q(chan_out[i])
        );

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                out_q[i] <= 1'b0;
            end else begin
                out_q[i] <= act_cfg_q[i].direct ? pd_raw.lvl : chan_out[i]; // [RULE2] [RULE16]
            end
        end
    end

    assign first_pair_out_a = out_q[0];
    assign first_pair_out_b = out_q[0];
    assign second_pair_out_a = out_q[1];
    assign second_pair_out_b = out_q[1];

    // checking helpers: input rises counted from each divided rise, source for prediv and divider input for channel 0
    logic [2:0] pd_span_q;
    logic pd_ok_q;
    logic [5:0] c0_span_q;
    logic c0_ok_q;
    logic c0_prev_q;
    logic c0_rise;
    logic c0_fall;

    assign c0_rise = chan_out[0] && !c0_prev_q;
    assign c0_fall = !chan_out[0] && c0_prev_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_span_q <= 3'h0;
            pd_ok_q <= 1'b0;
        end else if (sync_hold) begin
            pd_span_q <= 3'h0;
            pd_ok_q <= 1'b0;
        end else if (pd_div.rise) begin
            pd_span_q <= 3'h0;
            pd_ok_q <= 1'b1;
        end else if (pd_raw.rise) begin
            pd_span_q <= pd_span_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            c0_span_q <= 6'h00;
            c0_ok_q <= 1'b0;
            c0_prev_q <= 1'b0;
        end else begin
            c0_prev_q <= chan_out[0];
            if (sync_hold) begin
                c0_span_q <= 6'h00;
                c0_ok_q <= 1'b0;
            end else if (c0_rise) begin
                c0_span_q <= {5'h00, ch_in.rise};
                c0_ok_q <= 1'b1;
            end else if (ch_in.rise) begin
                c0_span_q <= c0_span_q + 6'h01;
            end
        end
    end

    default clocking ccd_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_src_vco_pick: assert property ( // [RULE1]
        !sync_hold && act_src_q == ccd_pkg::SRC_VCO_PD && $rose(vco_clk_in) |-> src_edge.rise)
        else $error("vco edge not taken as source");

    a_direct_route: assert property ( // [RULE2]
        act_cfg_q[0].direct && $past(act_cfg_q[0].direct) |-> first_pair_out_a == $past(pd_raw.lvl))
        else $error("direct route does not follow prediv input");

    a_prediv_period: assert property ( // [RULE4]
        pd_div.rise && pd_ok_q |-> pd_span_q == act_pd_ratio - 3'h1)
        else $error("prediv period differs from ratio");

    a_chan_period: assert property ( // [RULE8] [RULE3] [RULE5]
        c0_rise && c0_ok_q && !act_cfg_q[0].bypass
            |-> c0_span_q == ccd_pkg::ccd_ratio(act_cfg_q[0]))
        else $error("channel period differs from ratio");

    a_chan_high_time: assert property ( // [RULE12] [RULE11]
        c0_fall && c0_ok_q && !act_cfg_q[0].bypass
            |-> c0_span_q == (act_cfg_q[0].dcc_en
                ? (ccd_pkg::ccd_ratio(act_cfg_q[0]) >> 1)
                : {2'h0, act_cfg_q[0].high_w} + 6'h01))
        else $error("channel high time wrong");

    a_sync_quiet: assert property ( // [RULE19]
        sync_hold [*2] |-> !chan_out[0] && !chan_out[1])
        else $error("channel toggles during sync");

    a_cfg_frozen: assert property ( // [RULE23]
        !sync_hold |=> $stable(act_cfg_q) && $stable(act_pd_q) && $stable(act_src_q))
        else $error("settings changed outside sync");

    a_bypass_follow: assert property ( // [RULE6]
        act_cfg_q[0].bypass && !stretch_en[0] && !sync_hold && !$past(sync_hold)
            |-> chan_out[0] == $past(ch_in.lvl))
        else $error("bypass does not pass input");

    a_dcc_default: assert property ( // [RULE10]
        rst_n && sync_hold && !ctl_q[1][ccd_pkg::DUTY_FIX_DIS_BIT] |=> act_cfg_q[1].dcc_en)
        else $error("correction not enabled");
endmodule : ccd_clock_channel_divider

//--- sim/tb.sv
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_clk_in = 1'b0;
    logic vco_clk_in = 1'b0;
    logic [1:0] vcnt = 2'h0;
    logic o0a, o0b, o1a, o1b;
    logic [31:0] rd_val;
    logic rd_err;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int d0, d1;

    ccd_clock_channel_divider dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clk_in(ext_clk_in),
        .vco_clk_in(vco_clk_in), .first_pair_out_a(o0a), .first_pair_out_b(o0b),
        .second_pair_out_a(o1a), .second_pair_out_b(o1b));

    always #2.5 core_clk = ~core_clk;

    // ext toggles every cycle, vco runs at a quarter of the core rate
    always @(posedge core_clk) begin
        ext_clk_in <= ~ext_clk_in;
        vcnt <= vcnt + 2'h1;
        vco_clk_in <= vcnt[1];
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            conclude();
        end
    end

    task conclude();
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input string nm, input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(nm, {24'h0, e}, rd_val)
    endtask : rchk

    task cfg(input int ch, input logic [7:0] c, input logic [7:0] b, input logic [7:0] t);
        apb(1'b1, ch ? ccd_pkg::IDX_CH1_CYC : ccd_pkg::IDX_CH0_CYC, c);
        apb(1'b1, ch ? ccd_pkg::IDX_CH1_BYP : ccd_pkg::IDX_CH0_BYP, b);
        apb(1'b1, ch ? ccd_pkg::IDX_CH1_CTL : ccd_pkg::IDX_CH0_CTL, t);
    endtask : cfg

    // sync always launched at the same ext_clk_in phase
    task sync_now();
        @(posedge core_clk);
        while (ext_clk_in !== 1'b0) @(posedge core_clk);
        apb(1'b1, ccd_pkg::IDX_SYNC_CTL, 8'h01);
    endtask : sync_now

    task go(input logic [7:0] src, input logic [7:0] pd);
        apb(1'b1, ccd_pkg::IDX_SRC_SEL, src);
        apb(1'b1, ccd_pkg::IDX_PREDIV, pd);
        sync_now();
    endtask : go

    function automatic logic pick(input int ch);
        return ch ? o1a : o0a;
    endfunction : pick

    task lvl(input int ch, input logic v);
        do @(posedge core_clk); while (pick(ch) !== v);
    endtask : lvl

    // high time and period in core cycles, after two settling periods
    task mchk(input string nm, input int ch, input int eh, input int ep);
        int t;
        int hi;
        repeat (2) begin
            lvl(ch, 1'b0);
            lvl(ch, 1'b1);
        end
        t = cyc;
        `CHK("pair_b", pick(ch), ch ? o1b : o0b)
        lvl(ch, 1'b0);
        hi = cyc - t;
        lvl(ch, 1'b1);
        `CHK(nm, eh, hi)
        `CHK(nm, ep, cyc - t)
    endtask : mchk

    task dly(output int d);
        int t;
        sync_now();
        t = cyc;
        lvl(0, 1'b0);
        lvl(0, 1'b1);
        d = cyc - t;
    endtask : dly

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk("prediv", ccd_pkg::IDX_PREDIV, 8'h02);
        rchk("ctl0", ccd_pkg::IDX_CH0_CTL, 8'h00);
        rchk("ctl1", ccd_pkg::IDX_CH1_CTL, 8'h00);
        apb(1'b1, ccd_pkg::IDX_CH0_BYP, 8'hff);
        rchk("byp0", ccd_pkg::IDX_CH0_BYP, 8'h9f);
        apb(1'b0, 10'h100, 8'h00);
        `CHK("unmapped", 1'b1, rd_err)
        cfg(0, 8'h00, 8'h80, 8'h01);
        for (int r = 2; r <= 6; r++) begin
            go(8'h00, 8'(r));
            mchk("prediv", 0, 2 * (r / 2), 2 * r);
        end
        cfg(0, 8'h00, 8'h80, 8'h00);
        go(8'h00, 8'h03);
        mchk("dcc_byp", 0, 3, 6);
        cfg(0, 8'h21, 8'h00, 8'h01);
        cfg(1, 8'h00, 8'h00, 8'h00);
        go(8'h02, 8'h03);
        mchk("ch0_div", 0, 24, 60);
        mchk("ch1_div", 1, 12, 24);
        cfg(0, 8'h32, 8'h00, 8'h00);
        go(8'h01, 8'h02);
        mchk("odd_dcc", 0, 7, 14);
        cfg(1, 8'h00, 8'h00, 8'h02);
        apb(1'b1, ccd_pkg::IDX_CH0_CTL, 8'h02);
        go(8'h02, 8'h03);
        mchk("direct", 1, 2, 4);
        mchk("direct0", 0, 2, 4);
        cfg(0, 8'h20, 8'h00, 8'h01);
        apb(1'b1, ccd_pkg::IDX_SRC_SEL, 8'h01);
        dly(d0);
        apb(1'b1, ccd_pkg::IDX_CH0_BYP, 8'h03);
        dly(d1);
        `CHK("offset", d0 + 6, d1)
        apb(1'b1, ccd_pkg::IDX_CH0_BYP, 8'h11);
        dly(d1);
        `CHK("start_high", d0 + 8, d1)
        conclude();
    end
endmodule : tb
